//--- hdl/ipv_pkg.sv
// Constants and source tables for the interrupt priority and vector resolver
package ipv_pkg;
  // ----------------------------------------------------------------
  // Sources and widths
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 29;           // Non-maskable, 6 external, 22 on-chip
  localparam int NUM_LREG = 6;           // Level registers a..f
  localparam int VEC_W = 9;              // Widest vector entry address
  localparam logic [4:0] SRC_NMI = 5'h00;
  // Sources whose request is caught on a rising edge and held until taken
  localparam logic [NUM_SRC-1:0] HELD_SRC = 29'h7d;
  // ----------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_LEVEL_A = 4'h0;
  localparam logic [3:0] IDX_LEVEL_F = 4'h5;
  localparam logic [3:0] IDX_STATUS = 4'h6;
  localparam logic [3:0] IDX_MASK = 4'h7;
  localparam logic [3:0] IDX_GRANT = 4'h8;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] LEVEL_WMASK = 8'h77;   // Bits 7 and 3 read zero
  localparam int HI_FIELD = 4;
  localparam int LO_FIELD = 0;
  // Status bits: accepted, non-maskable accepted, held off by cpu mask
  localparam int ST_ACC = 0;
  localparam int ST_NMI = 1;
  localparam int ST_BLK = 2;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [3:0] NMI_LEVEL = 4'h8;
  localparam int SETTLE_CYC = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Per-source tables, index 0 has the highest fixed order
  // ----------------------------------------------------------------
  localparam logic [0:NUM_SRC-1][7:0] VEC_MIN_TAB = '{
    8'h16, 8'h40, 8'h48, 8'h50, 8'h52, 8'h58, 8'h5a,
    8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6c, 8'h6e,
    8'h70, 8'h72, 8'h74, 8'h76, 8'h78, 8'h7a, 8'h7c,
    8'h80, 8'h82, 8'h84, 8'h88, 8'h8a, 8'h8c, 8'h90};
  // Level group: even = bits 6..4, odd = bits 2..0 of register group/2
  localparam logic [0:NUM_SRC-1][3:0] GRP_TAB = '{
    4'hf, 4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3,
    4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5, 4'h5,
    4'h6, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7,
    4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9, 4'ha};
  // Rank inside a module, larger wins (capture 3 .. overflow 0)
  localparam logic [0:NUM_SRC-1][1:0] RANK_TAB = '{
    2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0,
    2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0,
    2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0,
    2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
endpackage : ipv_pkg

//--- hdl/ipv_resolver.sv
// Interrupt priority resolver and vector generator with AXI4-Lite registers
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Highest programmed group level wins first
// - Same module, equal level: larger rank wins
// - Equal level across sources: fixed global order
// - Vector address per source, doubled in maximum mode
// - Two 3-bit fields, other bits read zero
// - Reset clears all six level registers
// - Accept only when level exceeds cpu mask
// - New level takes effect after two clocks
module ipv_resolver
  import ipv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [NUM_SRC-1:0] src_req_i,    // Raw requests, index 0 non-maskable
  input wire logic [2:0] cpu_mask_i,           // Cpu mask level
  input wire logic max_mode_i,                 // High selects 4-byte vector entries
  input wire logic grant_ack_i,                // Cpu takes the offered vector
  output logic grant_valid_o,
  output logic [VEC_W-1:0] grant_vec_o,
  output logic [3:0] grant_lvl_o,
  output logic irq_o,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [NUM_LREG-1:0][7:0] level_reg;   // Software view of levels a..f
  logic [NUM_LREG-1:0][7:0] level_s1;    // First settle stage
  logic [NUM_LREG-1:0][7:0] level_s2;    // Level used by arbitration
  logic [2:0] status;                    // Sticky events
  logic [2:0] status_ev;                 // Events raised in this cycle
  logic [2:0] irq_mask;                  // Enables status onto irq_o
  logic [NUM_SRC-1:0] req_q;             // Previous raw request, for edges
  logic [NUM_SRC-1:0] held;              // Caught edge requests
  logic [NUM_SRC-1:0] live;              // Requests entering arbitration
  logic [NUM_SRC-1:0] next_clr;          // Held bit taken by the cpu
  logic [3:0] win_lvl;                   // Arbitration winner level
  logic [4:0] win_idx;                   // Arbitration winner index
  logic win_any;                         // Some request present
  logic accept;                          // Winner beats the cpu mask
  logic [4:0] grant_idx;                 // Index behind the offer
  logic aw_full, w_full;                 // Write halves captured
  logic [3:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  logic wr_hit;
  logic [3:0] ar_idx;

  // ----------------------------------------------------------------
  // Source conditioning
  // ----------------------------------------------------------------
  // Edge sources are caught and kept; a new edge beats the clear
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      req_q <= '0;
      held <= '0;
    end else begin
      req_q <= src_req_i;
      held <= (held & ~next_clr) | (src_req_i & ~req_q & HELD_SRC);
    end
  end

  // Cpu acceptance drops the held copy of the granted source
  always_comb begin
    next_clr = '0;
    if (grant_valid_o && grant_ack_i) begin
      next_clr[grant_idx] = 1'b1;
    end
  end

  assign live = (held & HELD_SRC) | (src_req_i & ~HELD_SRC);

  // ----------------------------------------------------------------
  // Level settle pipeline
  // ----------------------------------------------------------------
  // Two stages, so a rewritten level counts two clocks later
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      level_s1 <= '0;
      level_s2 <= '0;
    end else begin
      level_s1 <= level_reg;
      level_s2 <= level_s1;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Scan from index 0 up; only a strictly higher level displaces,
  // so ties keep the earlier index, which is the fixed order
  always_comb begin
    logic [3:0] lvl;
    lvl = '0;
    win_lvl = '0;
    win_idx = '0;
    win_any = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (GRP_TAB[i] == 4'hf) begin
        lvl = NMI_LEVEL;
      end else if (GRP_TAB[i][0]) begin
        lvl = {1'b0, level_s2[GRP_TAB[i][3:1]][LO_FIELD +: 3]};
      end else begin
        lvl = {1'b0, level_s2[GRP_TAB[i][3:1]][HI_FIELD +: 3]};
      end
      if (live[i] && (!win_any || lvl > win_lvl)) begin
        win_lvl = lvl;
        win_idx = 5'(i);   // rank falls with index inside a module
        win_any = 1'b1;
      end
    end
  end

  assign accept = win_any && (win_lvl > {1'b0, cpu_mask_i});

  // ----------------------------------------------------------------
  // Grant offer
  // ----------------------------------------------------------------
  // The offer freezes until acked, so the cpu sees one stable pair
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      grant_valid_o <= 1'b0;
      grant_vec_o <= '0;
      grant_lvl_o <= '0;
      grant_idx <= '0;
    end else if (!grant_valid_o || grant_ack_i) begin
      grant_valid_o <= accept && !(next_clr[win_idx]);
      grant_lvl_o <= win_lvl;
      grant_idx <= win_idx;
      if (max_mode_i) begin
        grant_vec_o <= {VEC_MIN_TAB[win_idx], 1'b0};
      end else begin
        grant_vec_o <= {1'b0, VEC_MIN_TAB[win_idx]};
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_hit = (aw_idx <= IDX_MASK);

  // Address and data halves land in either order
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= '0;
      w_byte <= '0;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_idx <= (s_axi_awaddr[31:6] == '0) ? s_axi_awaddr[5:2] : 4'hf;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Level registers, only byte lane 0 carries them
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      level_reg <= {NUM_LREG{LEVEL_RST}};
    end else if (wr_fire && w_lane0 && aw_idx <= IDX_LEVEL_F) begin
      level_reg[aw_idx[2:0]] <= w_byte & LEVEL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  // Events of this cycle, kept apart so the flop process stays non-blocking
  always_comb begin
    status_ev = '0;
    status_ev[ST_ACC] = grant_valid_o && grant_ack_i;
    status_ev[ST_NMI] = grant_valid_o && grant_ack_i && grant_idx == SRC_NMI;
    status_ev[ST_BLK] = win_any && !accept;
  end

  // Write one clears; an event in the same cycle stays set
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      status <= STATUS_RST;
      irq_mask <= STATUS_RST;
    end else begin
      if (wr_fire && w_lane0 && aw_idx == IDX_STATUS) begin
        status <= (status & ~w_byte[2:0]) | status_ev;
      end else begin
        status <= status | status_ev;
      end
      if (wr_fire && w_lane0 && aw_idx == IDX_MASK) begin
        irq_mask <= w_byte[2:0];
      end
    end
  end

  assign irq_o = |(status & irq_mask);

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx = (s_axi_araddr[31:6] == '0) ? s_axi_araddr[5:2] : 4'hf;

  // One read at a time, answered the cycle after the address
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      if (ar_idx <= IDX_LEVEL_F) begin
        s_axi_rdata <= {24'h0, level_reg[ar_idx[2:0]]};
      end else if (ar_idx == IDX_STATUS) begin
        s_axi_rdata <= {29'h0, status};
      end else if (ar_idx == IDX_MASK) begin
        s_axi_rdata <= {29'h0, irq_mask};
      end else if (ar_idx == IDX_GRANT) begin
        s_axi_rdata <= {11'h0, grant_idx, 3'h0, grant_vec_o, grant_lvl_o};
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_lvl_write;
    wr_fire && w_lane0 && aw_idx == IDX_LEVEL_A;
  endsequence

  sequence s_offer_load;
    (!grant_valid_o || grant_ack_i) && accept;
  endsequence

  a_level_settle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_lvl_write ##1 !(wr_fire && aw_idx == IDX_LEVEL_A)
      |-> ##2 level_s2[0] == $past(level_reg[0], 2))
    else $error("level change not settled after two clocks");

  a_level_late: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_lvl_write ##1 $changed(level_reg[0]) |-> level_s2[0] == $past(level_s2[0]))
    else $error("level change used too early");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_axi_rvalid && $past(s_axi_arvalid && ar_idx <= IDX_LEVEL_F)
      |-> (s_axi_rdata[7] == 1'b0 && s_axi_rdata[3] == 1'b0))
    else $error("reserved level bit read as one");

  a_reset_clear: assert property (@(posedge core_clk_i)
    sys_rst_i |=> level_reg == '0 && !grant_valid_o)
    else $error("levels not cleared by reset");

  a_mask_gate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    grant_valid_o && !$past(grant_valid_o) |-> $past(win_lvl) > {1'b0, $past(cpu_mask_i)})
    else $error("offer at or below cpu mask");

  a_offer_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    grant_valid_o && !grant_ack_i |=> grant_valid_o && $stable(grant_vec_o)
      && $stable(grant_lvl_o))
    else $error("offer changed before ack");

  a_vec_mode: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    s_offer_load ##1 grant_valid_o |-> grant_vec_o == ($past(max_mode_i)
      ? {VEC_MIN_TAB[grant_idx], 1'b0} : {1'b0, VEC_MIN_TAB[grant_idx]}))
    else $error("vector address does not match mode");

  a_win_level: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    win_any |-> live[win_idx] && (win_idx == SRC_NMI || win_lvl < NMI_LEVEL))
    else $error("winner not a live request");

  a_nmi_first: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    live[SRC_NMI] |-> win_idx == SRC_NMI && win_lvl == NMI_LEVEL)
    else $error("non-maskable request lost arbitration");

  a_rank_tie: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    win_any && win_idx < 5'(NUM_SRC - 1) && live[win_idx + 5'h1]
      && GRP_TAB[win_idx] == GRP_TAB[win_idx + 5'h1]
      |-> RANK_TAB[win_idx] > RANK_TAB[win_idx + 5'h1])
    else $error("lower in-module rank won a tie");

endmodule : ipv_resolver
`default_nettype wire

//--- bench/ipv_cpu_model.sv
// Cpu sequencer model that takes offered vectors and keeps the last one
`timescale 1ns/1ps
`default_nettype none
module ipv_cpu_model
  import ipv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] wait_i,           // Stall cycles before taking an offer
  input wire logic grant_valid_i,
  input wire logic [VEC_W-1:0] grant_vec_i,
  input wire logic [3:0] grant_lvl_i,
  output logic grant_ack_o,
  output logic [VEC_W-1:0] seen_vec_o,     // Last vector taken
  output logic [3:0] seen_lvl_o,           // Level taken with it
  output logic [7:0] taken_o               // Offers taken so far
);
  logic [3:0] stall;                       // Cycles spent on the present offer
  // ----------------------------------------------------------------
  // Take logic
  // ----------------------------------------------------------------
  // One ack per offer; never a second ack while the first is in flight
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      grant_ack_o <= 1'b0;
      seen_vec_o <= '0;
      seen_lvl_o <= 4'h0;
      taken_o <= 8'h00;
      stall <= 4'h0;
    end else if (grant_valid_i && !grant_ack_o && stall >= wait_i) begin
      grant_ack_o <= 1'b1;
      seen_vec_o <= grant_vec_i;           // Vector and level latched together
      seen_lvl_o <= grant_lvl_i;
      taken_o <= taken_o + 8'h01;
      stall <= 4'h0;
    end else begin
      grant_ack_o <= 1'b0;
      stall <= grant_valid_i ? stall + 4'h1 : 4'h0;
    end
  end
endmodule : ipv_cpu_model
`default_nettype wire

//--- bench/tb_irq_priority_vector_resolver.sv
// Self-checking bench for the interrupt priority and vector resolver
`timescale 1ns/1ps
`default_nettype none
module tb_irq_priority_vector_resolver
  import ipv_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [NUM_SRC-1:0] src_req_i = '0;
  logic [2:0] cpu_mask_i = 3'h0;
  logic max_mode_i = 1'b0;
  logic grant_ack_i, grant_valid_o, irq_o;
  logic [VEC_W-1:0] grant_vec_o, seen_vec;
  logic [3:0] grant_lvl_o, seen_lvl;
  logic [3:0] pwait = 4'h0;                // Cpu stall, varied per offer
  logic [7:0] taken;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] lv [NUM_LREG];               // Level bytes the bench expects
  logic [31:0] seed = 32'h8f95;
  int miscompares = 0;
  int total_checks = 0;
  ipv_resolver i_dut (.core_clk_i, .sys_rst_i, .src_req_i, .cpu_mask_i, .max_mode_i,
    .grant_ack_i, .grant_valid_o, .grant_vec_o, .grant_lvl_o, .irq_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ipv_cpu_model i_cpu (.core_clk_i, .sys_rst_i, .wait_i(pwait), .grant_valid_i(grant_valid_o),
    .grant_vec_i(grant_vec_o), .grant_lvl_i(grant_lvl_o), .grant_ack_o(grant_ack_i),
    .seen_vec_o(seen_vec), .seen_lvl_o(seen_lvl), .taken_o(taken));
  // Clock at 100 ns
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Level of one source from the bench's copy of the level bytes
  function automatic int lvl_of(input int i);
    logic [3:0] g;
    if (i == 0) return 8;
    g = GRP_TAB[i];
    return g[0] ? int'(lv[g[3:1]][2:0]) : int'(lv[g[3:1]][6:4]);
  endfunction : lvl_of
  // Winner: highest level, lower index on a tie (fixed order)
  function automatic int exp_win(input logic [NUM_SRC-1:0] r);
    int b = -1;
    int bl = -1;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (r[i] && lvl_of(i) > bl) begin
        b = i;
        bl = lvl_of(i);
      end
    end
    return b;
  endfunction : exp_win
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Write: both halves offered together, each released when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Raise requests, let the cpu take what is offered, compare the result
  task automatic arb(input logic [NUM_SRC-1:0] q, input logic [2:0] m, input logic mm);
    int w;
    int k;
    logic [7:0] n0;
    w = exp_win(q);
    n0 = taken;
    cpu_mask_i <= m;
    max_mode_i <= mm;
    pwait <= 4'(rnd() % 4);
    @(posedge core_clk_i);
    src_req_i <= q;
    if (w >= 0 && lvl_of(w) > int'(m)) begin
      for (k = 0; k < 40 && taken == n0; k++) @(posedge core_clk_i);
      chk("taken", 32'(n0) + 32'h1, 32'(taken));
      src_req_i <= '0;
      for (k = 0; k < 40 && (grant_valid_o || grant_ack_i); k++) @(posedge core_clk_i);
      chk("offer idle", 32'h0, 32'(grant_valid_o));
      chk("vector", 32'(VEC_MIN_TAB[w]) << mm, 32'(seen_vec));
      chk("level", lvl_of(w), 32'(seen_lvl));
    end else begin
      repeat (6) @(posedge core_clk_i);
      chk("offer", 32'h0, 32'(grant_valid_o));
      src_req_i <= '0;
    end
  endtask : arb
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      axi_rd(i * 4, d, r);
      chk("reset value", 32'h0, d);
    end
    for (int i = 0; i < NUM_LREG; i++) begin
      axi_wr(i * 4, 32'hffffffff, r);
      axi_rd(i * 4, d, r);
      chk("level bits", 32'h77, d);
      lv[i] = 8'h77;
    end
    axi_rd(32'h24, d, r);
    chk("read resp", 32'(RESP_SLVERR), 32'(r));
    axi_wr(32'h40, 32'h1, r);
    chk("write resp", 32'(RESP_SLVERR), 32'(r));
    $display("test registers done");
    // All at level 7: global order, in-module rank, mask at the level
    arb(~HELD_SRC, 3'h6, 1'b0);
    arb(29'h700, 3'h0, 1'b1);
    arb(~HELD_SRC, 3'h7, 1'b0);
    $display("test corner cases done");
    for (int n = 0; n < 40; n++) begin
      for (int i = 0; i < NUM_LREG; i++) begin
        d = rnd();
        axi_wr(i * 4, d, r);
        lv[i] = d[7:0] & 8'h77;
      end
      arb(NUM_SRC'(rnd() & rnd()) & ~HELD_SRC, 3'(rnd()), rnd() > 32'h80000000);
    end
    $display("test random arbitration done");
    // A raised level must not count until it has settled for two clocks
    cpu_mask_i <= 3'h0;
    axi_wr(32'h0, 32'h0, r);
    axi_wr(32'h0, 32'h70, r);
    lv[0] = 8'h70;
    src_req_i <= 29'h2;
    repeat (2) @(posedge core_clk_i);
    chk("early offer", 32'h0, 32'(grant_valid_o));
    @(posedge core_clk_i);
    chk("settled offer", 32'h1, 32'(grant_valid_o));
    src_req_i <= '0;
    for (int k = 0; k < 40 && (grant_valid_o || grant_ack_i); k++) @(posedge core_clk_i);
    chk("settle idle", 32'h0, 32'(grant_valid_o));
    $display("test level settle done");
    arb(29'h1, 3'h7, 1'b1);
    chk("irq masked", 32'h0, 32'(irq_o));
    axi_wr(32'h1c, 32'h1, r);
    chk("irq raised", 32'h1, 32'(irq_o));
    axi_wr(32'h18, 32'h7, r);
    chk("irq cleared", 32'h0, 32'(irq_o));
    $display("test interrupt done");
    print_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk_i);
    miscompares++;
    print_verdict();
  end
endmodule : tb_irq_priority_vector_resolver
`default_nettype wire
